// ### hw/dpd_pkg.sv
// Package of constants for the eight-channel input parameter and diagnostic record block.
package dpd_pkg;

  // Clock and time base.
  localparam int unsigned CLK_PERIOD_NS = 10;    // System clock period in ns.
  localparam int unsigned US_NS         = 1000;  // One microsecond in ns.
  localparam int unsigned US_CYCLES     = US_NS / CLK_PERIOD_NS; // Cycles per microsecond.

  // Record numbers of the record-number access path.
  localparam logic [7:0] REC_PARAM      = 8'h00; // Enable bytes; also short diag read.
  localparam logic [7:0] REC_DIAG       = 8'h01; // Full diagnostic record.
  localparam logic [7:0] REC_FILT_FIRST = 8'h80; // Filter byte of channels 0 and 1.
  localparam logic [7:0] REC_FILT_LAST  = 8'h83; // Filter byte of channels 6 and 7.

  // Indices of the index-based access path.
  localparam logic [15:0] IX_PARAM_FIRST = 16'h3100; // Interrupt enable byte.
  localparam logic [15:0] IX_PARAM_LAST  = 16'h3105; // Last filter byte.
  localparam logic [15:0] IX_DIAG_SHORT  = 16'h2f00; // First four diagnostic bytes.
  localparam logic [15:0] IX_DIAG_FULL   = 16'h2f01; // Full diagnostic record.

  // Record lengths in bytes.
  localparam logic [4:0] DIAG_LEN       = 5'h14; // Full diagnostic record.
  localparam logic [4:0] DIAG_SHORT_LEN = 5'h04; // Short diagnostic read.
  localparam logic [4:0] PARAM_LEN      = 5'h02; // Enable-byte record.

  // Parameter values and reset values.
  localparam logic [7:0] DIAG_INTERRUPT_ENABLE_OFF = 8'h00; // Diagnostic interrupt off.
  localparam logic [7:0] DIAG_INTERRUPT_ENABLE_ON  = 8'h40; // Diagnostic interrupt on.
  localparam logic [7:0] WBE_RESET   = 8'h00; // No wire-break detection.
  localparam logic [7:0] FILT_RESET  = 8'h11; // Shortest filter on both channels.

  // Fixed diagnostic bytes.
  localparam logic [7:0] MOD_CLASS_INFO = 8'h1f; // Digital class, channel info present.
  localparam logic [7:0] CHAN_KIND      = 8'h70; // Digital input.
  localparam logic [7:0] DIAG_BITS_CH   = 8'h08; // Diagnostic bits per channel.
  localparam logic [7:0] CHAN_COUNT     = 8'h08; // Channels of the module.

  // Byte positions inside the diagnostic record.
  localparam logic [4:0] B_SUMMARY   = 5'h00;
  localparam logic [4:0] B_CLASS     = 5'h01;
  localparam logic [4:0] B_SPARE     = 5'h02;
  localparam logic [4:0] B_INTERNAL  = 5'h03;
  localparam logic [4:0] B_KIND      = 5'h04;
  localparam logic [4:0] B_BITS      = 5'h05;
  localparam logic [4:0] B_COUNT     = 5'h06;
  localparam logic [4:0] B_CHMAP     = 5'h07;
  localparam logic [4:0] B_CHDETAIL  = 5'h08; // First of eight detail bytes.
  localparam logic [4:0] B_TIMESTAMP = 5'h10; // Low byte of four, little endian.

  // Bit positions of the summary, internal and detail bytes.
  localparam int SUM_MODFAIL = 0;
  localparam int SUM_INTERN  = 1;
  localparam int SUM_EXTERN  = 2;
  localparam int SUM_CHAN    = 3;
  localparam int SUM_AUX     = 4;
  localparam int SUM_PARAM   = 7;
  localparam int INT_OVF     = 3;
  localparam int INT_COMM    = 4;
  localparam int DET_PARAM   = 0;
  localparam int DET_WBRK    = 4;

  // Filter codes and their delays in microseconds.
  localparam logic [3:0]  FC_MIN = 4'h1;
  localparam logic [3:0]  FC_MAX = 4'h7;
  localparam logic [14:0] FT_US_1 = 15'd100;
  localparam logic [14:0] FT_US_2 = 15'd400;
  localparam logic [14:0] FT_US_3 = 15'd800;
  localparam logic [14:0] FT_US_4 = 15'd1600;
  localparam logic [14:0] FT_US_5 = 15'd3200;
  localparam logic [14:0] FT_US_6 = 15'd10000;
  localparam logic [14:0] FT_US_7 = 15'd20000;

endpackage

// ### hw/dpd_records.sv
// Parameter and diagnostic record logic of an eight-channel digital input module.
`timescale 1ns/1ns

module dpd_records #(
  parameter int unsigned US_DIV = dpd_pkg::US_CYCLES // Cycles per microsecond tick.
) (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Field side.
  input  wire logic [7:0]  input_channel,      // Raw input levels.
  input  wire logic [7:0]  wire_break_in,      // Open-circuit detectors per channel.
  input  wire logic        aux_supply_missing, // External supply absent.
  input  wire logic        int_comm_error,     // Internal communication fault.
  input  wire logic        diag_buf_overflow,  // Internal diagnostics buffer overflow.
  // Record access port.
  input  wire logic        rec_rd,             // Read request pulse.
  input  wire logic        rec_wr,             // Write request pulse.
  input  wire logic        use_index,          // Address by object_index, not record.
  input  wire logic [7:0]  record_number,
  input  wire logic [15:0] object_index,
  input  wire logic [4:0]  rec_byte,           // Byte offset inside the record.
  input  wire logic [7:0]  rec_wdata,
  output logic      [7:0]  rec_rdata,
  output logic             rec_ack,            // Answer pulse, one cycle after request.
  output logic             rec_err,            // Answer refused, with rec_ack.
  // Results.
  output logic      [7:0]  input_filtered,     // Debounced input levels.
  output logic             diag_irq            // Diagnostic interrupt pulse.
);

  // Parameter state.
  logic [7:0]  diag_interrupt_enable_reg, diag_interrupt_enable_next;           // Diagnostic interrupt enable.
  logic [7:0]  wbe_reg, wbe_next;                   // Wire-break enable per channel.
  logic [7:0]  filt_reg [4], filt_next [4];         // Filter bytes, one per channel pair.
  // Record port answer.
  logic [7:0]  rdata_reg, rdata_next;
  logic        ack_reg, ack_next;
  logic        err_reg, err_next;
  // Time base.
  logic [15:0] div_reg, div_next;                   // Microsecond divider.
  logic        tick_reg, tick_next;                 // One-cycle microsecond enable.
  logic [31:0] us_reg, us_next;                     // Free-running microsecond counter.
  logic [31:0] ts_reg, ts_next;                     // Timestamp of last diagnostic event.
  // Diagnostic event detection.
  logic [87:0] ev_prev_reg, ev_prev_next;           // Error vector one cycle ago.
  logic        irq_reg, irq_next;
  // Input filters.
  logic [7:0]  dfilt_reg, dfilt_next;
  logic [14:0] fcnt_reg [8], fcnt_next [8];

  // Combinational diagnostic picture.
  logic [3:0]  code   [8];                          // Filter code per channel.
  logic [7:0]  perr;                                // Illegal filter code per channel.
  logic [7:0]  wbrep;                               // Reported wire breaks.
  logic [7:0]  chd    [8];                          // Per-channel detail bytes.
  logic [7:0]  chmap;
  logic [7:0]  summary;
  logic [7:0]  internal;
  logic [87:0] ev;
  logic        new_err;

  // Per-channel filter code, detail byte and debounce filter.
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_ch
      logic [14:0] lim_us;
      // Even channel takes the low nibble, odd channel the high one.
      assign code[g] = (g % 2 == 0) ? filt_reg[g / 2][3:0] : filt_reg[g / 2][7:4];
      assign perr[g] = (code[g] < dpd_pkg::FC_MIN) || (code[g] > dpd_pkg::FC_MAX);
      // A break only counts on an armed channel.
      assign wbrep[g] = wire_break_in[g] & wbe_reg[g];
      assign chd[g] = ({7'h00, perr[g]} << dpd_pkg::DET_PARAM)
                    | ({7'h00, wbrep[g]} << dpd_pkg::DET_WBRK);
      assign chmap[g] = |chd[g];

      // Delay lookup; an illegal code falls back to the shortest time, so a bad
      // parameter never freezes the input.
      always_comb begin
        unique case (code[g])
          4'h2:    lim_us = dpd_pkg::FT_US_2;
          4'h3:    lim_us = dpd_pkg::FT_US_3;
          4'h4:    lim_us = dpd_pkg::FT_US_4;
          4'h5:    lim_us = dpd_pkg::FT_US_5;
          4'h6:    lim_us = dpd_pkg::FT_US_6;
          4'h7:    lim_us = dpd_pkg::FT_US_7;
          default: lim_us = dpd_pkg::FT_US_1;
        endcase
      end

      // Count microseconds while the raw level differs; any bounce restarts it.
      always_comb begin
        fcnt_next[g]  = fcnt_reg[g];
        dfilt_next[g] = dfilt_reg[g];
        if (input_channel[g] == dfilt_reg[g]) begin
          fcnt_next[g] = 15'd0;
        end else if (tick_reg) begin
          if (fcnt_reg[g] + 15'd1 >= lim_us) begin
            dfilt_next[g] = input_channel[g];
            fcnt_next[g]  = 15'd0;
          end else begin
            fcnt_next[g] = fcnt_reg[g] + 15'd1;
          end
        end
      end
    end
  endgenerate

  // Module summary and internal fault bytes.
  always_comb begin
    summary = 8'h00;
    internal = 8'h00;
    internal[dpd_pkg::INT_OVF]  = diag_buf_overflow;
    internal[dpd_pkg::INT_COMM] = int_comm_error;
    summary[dpd_pkg::SUM_AUX]    = aux_supply_missing;
    summary[dpd_pkg::SUM_INTERN] = |internal;
    summary[dpd_pkg::SUM_EXTERN] = aux_supply_missing | (|wbrep);
    summary[dpd_pkg::SUM_CHAN]   = |chmap;
    summary[dpd_pkg::SUM_PARAM]  = |perr;
    summary[dpd_pkg::SUM_MODFAIL] = summary[dpd_pkg::SUM_INTERN] | summary[dpd_pkg::SUM_EXTERN]
                                  | summary[dpd_pkg::SUM_CHAN] | summary[dpd_pkg::SUM_PARAM];
    ev = {summary, internal, chmap, chd[7], chd[6], chd[5], chd[4],
          chd[3], chd[2], chd[1], chd[0]};
  end

  // Any bit going from clear to set is one diagnostic event.
  assign new_err = |(ev & ~ev_prev_reg);

  // Diagnostic record byte by position; unused positions read zero.
  function automatic logic [7:0] diag_byte(input logic [4:0] pos);
    logic [7:0] b;
    b = 8'h00;
    if (pos >= dpd_pkg::B_TIMESTAMP) begin
      b = ts_reg[8 * (pos - dpd_pkg::B_TIMESTAMP) +: 8];
    end else if (pos >= dpd_pkg::B_CHDETAIL) begin
      b = chd[pos[2:0]];
    end else begin
      unique case (pos)
        dpd_pkg::B_SUMMARY:  b = summary;
        dpd_pkg::B_CLASS:    b = dpd_pkg::MOD_CLASS_INFO;
        dpd_pkg::B_INTERNAL: b = internal;
        dpd_pkg::B_KIND:     b = dpd_pkg::CHAN_KIND;
        dpd_pkg::B_BITS:     b = dpd_pkg::DIAG_BITS_CH;
        dpd_pkg::B_COUNT:    b = dpd_pkg::CHAN_COUNT;
        dpd_pkg::B_CHMAP:    b = chmap;
        default:             b = 8'h00;                   // Spare byte stays zero.
      endcase
    end
    return b;
  endfunction

  // Record access decode, register writes and read answer.
  always_comb begin
    logic [2:0] psel;     // 0 interrupt enable, 1 wire-break enable, 2..5 filter bytes.
    logic       pvalid;   // Request hits a parameter byte.
    logic [4:0] dlen;     // Diagnostic length reachable; zero when none.
    logic [7:0] pval;
    psel   = 3'd0;
    pvalid = 1'b0;
    dlen   = 5'd0;
    pval   = 8'h00;
    diag_interrupt_enable_next = diag_interrupt_enable_reg;
    wbe_next     = wbe_reg;
    filt_next    = filt_reg;
    rdata_next   = 8'h00;
    ack_next     = rec_rd | rec_wr;
    err_next     = 1'b0;
    if (use_index) begin
      // Each parameter index carries one byte.
      if (object_index >= dpd_pkg::IX_PARAM_FIRST && object_index <= dpd_pkg::IX_PARAM_LAST
          && rec_byte == 5'd0) begin
        psel   = 3'(object_index - dpd_pkg::IX_PARAM_FIRST);
        pvalid = 1'b1;
      end
      if (object_index == dpd_pkg::IX_DIAG_FULL) begin
        dlen = dpd_pkg::DIAG_LEN;
      end else if (object_index == dpd_pkg::IX_DIAG_SHORT) begin
        dlen = dpd_pkg::DIAG_SHORT_LEN;
      end
    end else begin
      if (record_number == dpd_pkg::REC_PARAM && rec_byte < dpd_pkg::PARAM_LEN) begin
        psel   = {2'b00, rec_byte[0]};
        pvalid = 1'b1;
      end else if (record_number >= dpd_pkg::REC_FILT_FIRST
                   && record_number <= dpd_pkg::REC_FILT_LAST && rec_byte == 5'd0) begin
        psel   = 3'(record_number - dpd_pkg::REC_FILT_FIRST) + 3'd2;
        pvalid = 1'b1;
      end
      if (record_number == dpd_pkg::REC_DIAG) begin
        dlen = dpd_pkg::DIAG_LEN;
      end else if (record_number == dpd_pkg::REC_PARAM) begin
        dlen = dpd_pkg::DIAG_SHORT_LEN;
      end
    end
    // Current value of the selected parameter byte.
    unique case (psel)
      3'd0:    pval = diag_interrupt_enable_reg;
      3'd1:    pval = wbe_reg;
      default: pval = filt_reg[psel[1:0] - 2'd2];
    endcase
    if (rec_wr) begin
      if (!pvalid) begin
        err_next = 1'b1;
      end else if (psel == 3'd0) begin
        // Any value other than the two legal ones is refused and not stored.
        if (rec_wdata == dpd_pkg::DIAG_INTERRUPT_ENABLE_OFF || rec_wdata == dpd_pkg::DIAG_INTERRUPT_ENABLE_ON) begin
          diag_interrupt_enable_next = rec_wdata;
        end else begin
          err_next = 1'b1;
        end
      end else if (psel == 3'd1) begin
        wbe_next = rec_wdata;
      end else begin
        // Illegal nibbles are stored and flagged as parameter errors.
        filt_next[psel[1:0] - 2'd2] = rec_wdata;
      end
    end else if (rec_rd) begin
      // Reads of record zero go to the short diagnostic view.
      if (dlen != 5'd0) begin
        if (rec_byte < dlen) begin
          rdata_next = diag_byte(rec_byte);
        end else begin
          err_next = 1'b1;
        end
      end else if (pvalid) begin
        rdata_next = pval;
      end else begin
        err_next = 1'b1;
      end
    end
  end

  // Time base, timestamp and interrupt.
  always_comb begin
    div_next  = div_reg + 16'd1;
    tick_next = 1'b0;
    us_next   = us_reg;
    if (div_reg >= 16'(US_DIV - 1)) begin
      div_next  = 16'd0;
      tick_next = 1'b1;
    end
    if (tick_reg) begin
      us_next = us_reg + 32'd1;
    end
    ts_next      = new_err ? us_reg : ts_reg;
    irq_next     = new_err && (diag_interrupt_enable_reg == dpd_pkg::DIAG_INTERRUPT_ENABLE_ON);
    ev_prev_next = ev;
  end

  // All state registers; reset sets parameters to their defaults.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      diag_interrupt_enable_reg <= dpd_pkg::DIAG_INTERRUPT_ENABLE_OFF;
      wbe_reg     <= dpd_pkg::WBE_RESET;
      for (int i = 0; i < 4; i++) begin
        filt_reg[i] <= dpd_pkg::FILT_RESET;
      end
      for (int i = 0; i < 8; i++) begin
        fcnt_reg[i] <= 15'd0;
      end
      rdata_reg   <= 8'h00;
      ack_reg     <= 1'b0;
      err_reg     <= 1'b0;
      div_reg     <= 16'd0;
      tick_reg    <= 1'b0;
      us_reg      <= 32'd0;
      ts_reg      <= 32'd0;
      ev_prev_reg <= 88'd0;
      irq_reg     <= 1'b0;
      dfilt_reg   <= 8'h00;
    end else begin
      diag_interrupt_enable_reg <= diag_interrupt_enable_next;
      wbe_reg     <= wbe_next;
      filt_reg    <= filt_next;
      fcnt_reg    <= fcnt_next;
      rdata_reg   <= rdata_next;
      ack_reg     <= ack_next;
      err_reg     <= err_next;
      div_reg     <= div_next;
      tick_reg    <= tick_next;
      us_reg      <= us_next;
      ts_reg      <= ts_next;
      ev_prev_reg <= ev_prev_next;
      irq_reg     <= irq_next;
      dfilt_reg   <= dfilt_next;
    end
  end

  assign rec_rdata      = rdata_reg;
  assign rec_ack        = ack_reg;
  assign rec_err        = err_reg;
  assign input_filtered = dfilt_reg;
  assign diag_irq       = irq_reg;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_DIAGEN_LEGAL: assert property (
    diag_interrupt_enable_reg == dpd_pkg::DIAG_INTERRUPT_ENABLE_OFF || diag_interrupt_enable_reg == dpd_pkg::DIAG_INTERRUPT_ENABLE_ON)
    else $error("Interrupt enable holds an illegal value.");
  AST_FILT_RESET: assert property (
    $fell(rst) |-> filt_reg[0] == dpd_pkg::FILT_RESET && filt_reg[3] == dpd_pkg::FILT_RESET)
    else $error("Filter byte not at reset value after reset.");
  AST_WB_ARMED: assert property (
    (chmap & ~perr) != 8'h00 |-> ((chmap & ~perr) & ~wbe_reg) == 8'h00)
    else $error("Wire break reported on an unarmed channel.");
  AST_AUX: assert property (
    aux_supply_missing |-> summary[dpd_pkg::SUM_AUX] && summary[dpd_pkg::SUM_MODFAIL])
    else $error("Missing supply not flagged in summary.");
  AST_US_COUNT: assert property (
    tick_reg |=> us_reg == $past(us_reg) + 32'd1)
    else $error("Microsecond counter did not advance on tick.");
  AST_TS_CAPTURE: assert property (
    new_err |=> ts_reg == $past(us_reg))
    else $error("Timestamp did not capture counter at event.");
  AST_IRQ: assert property (
    diag_irq |-> $past(new_err) && $past(diag_interrupt_enable_reg) == dpd_pkg::DIAG_INTERRUPT_ENABLE_ON)
    else $error("Interrupt without enabled new error.");
  AST_SHORT_READ: assert property (
    rec_rd && !use_index && record_number == dpd_pkg::REC_PARAM && rec_byte >= 5'd4
    |=> rec_ack && rec_err)
    else $error("Short diagnostic read beyond four bytes not refused.");
  AST_CLASS_READ: assert property (
    rec_rd && use_index && object_index == dpd_pkg::IX_DIAG_FULL && rec_byte == 5'd1
    |=> rec_ack && !rec_err && rec_rdata == dpd_pkg::MOD_CLASS_INFO)
    else $error("Class byte read wrong on index path.");
  AST_FILT_STABLE: assert property (
    input_filtered != $past(input_filtered) |-> $past(tick_reg))
    else $error("Filtered input moved without a timer tick.");
  // Parameter writes land one cycle after the request; the first filter record and the
  // wire-break byte cover both arms of the record-number decode.
  AST_FILT_WRITE: assert property (
    rec_wr && !use_index && record_number == dpd_pkg::REC_FILT_FIRST && rec_byte == 5'd0
    |=> filt_reg[0] == $past(rec_wdata))
    else $error("Filter record write did not land in the first filter byte.");
  AST_WBE_WRITE: assert property (
    rec_wr && !use_index && record_number == dpd_pkg::REC_PARAM && rec_byte == 5'd1
    |=> wbe_reg == $past(rec_wdata))
    else $error("Wire-break enable write did not land.");
  // An armed break is an external and a channel error at once, so both summary bits
  // and the module failure bit must follow it in the same cycle.
  AST_BREAK_SUMMARY: assert property (
    (wire_break_in & wbe_reg) != 8'h00
    |-> summary[dpd_pkg::SUM_EXTERN] && summary[dpd_pkg::SUM_CHAN]
        && summary[dpd_pkg::SUM_MODFAIL])
    else $error("Armed wire break missing from the summary byte.");

  COV_IRQ:      cover property (diag_irq);
  COV_FILT:     cover property ($changed(input_filtered));
  COV_DIAGREAD: cover property (rec_rd && record_number == dpd_pkg::REC_DIAG ##1 rec_ack);
  COV_BADEN:    cover property (rec_wr && use_index && object_index == dpd_pkg::IX_PARAM_FIRST
                                && rec_wdata == 8'h12 ##1 rec_err);

endmodule

// ### tb/dpd_host.sv
// Host model that issues single-byte record requests to the record block.
`timescale 1ns/1ns
module dpd_host (
  // Clock.
  input  wire logic        clk_sys,
  // Record request lines.
  output logic             rec_rd,
  output logic             rec_wr,
  output logic             use_index,
  output logic      [7:0]  record_number,
  output logic      [15:0] object_index,
  output logic      [4:0]  rec_byte,
  output logic      [7:0]  rec_wdata
);
  // Lines idle at time zero, so nothing can be taken during reset.
  initial begin
    {rec_rd, rec_wr, use_index, record_number, object_index, rec_byte, rec_wdata} = '0;
  end

  // One request, held for exactly one taking edge. Afterwards the qualifiers show the
  // inverse of the last value, so a design that samples late sees garbage, not a copy.
  task automatic req(input logic w, input logic ix, input logic [7:0] rn,
                     input logic [15:0] oi, input logic [4:0] b, input logic [7:0] d);
    @(posedge clk_sys);
    rec_wr        <= w;
    rec_rd        <= ~w;
    use_index     <= ix;
    record_number <= rn;
    object_index  <= oi;
    rec_byte      <= b;
    rec_wdata     <= d;
    @(posedge clk_sys);
    {rec_rd, rec_wr} <= 2'b00;
    {use_index, record_number, object_index, rec_byte, rec_wdata} <= ~{ix, rn, oi, b, d};
  endtask
endmodule

// ### tb/di8_param_diag_records_bench.sv
// Self-checking bench of the parameter and diagnostic record block.
`timescale 1ns/1ns
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
  $display("BAD %0t got %h expected %h", $time, got, exp); end end
module di8_param_diag_records_bench;
  localparam int DIV = 2;               // Short microsecond tick keeps filter runs brief.
  logic        clk_sys = 1'b0;          // System clock.
  logic        rst = 1'b1;              // Synchronous reset.
  logic [7:0]  input_channel = 8'h00;   // Raw field inputs.
  logic [7:0]  wire_break_in = 8'h00;   // Open-circuit detectors.
  logic [2:0]  faults = 3'b000;         // Aux missing, comm error, overflow.
  logic        rec_rd, rec_wr, use_index, rec_ack, rec_err, diag_irq;
  logic [7:0]  record_number, rec_wdata, rec_rdata, input_filtered, wbe, f;
  logic [15:0] object_index;            // Index-path address.
  logic [4:0]  rec_byte;                // Byte inside the record.
  logic [8:0]  exp_q[$];                // Expected {err, data} per answer.
  logic [8:0]  exp_v;                   // Oldest note, taken off the queue exactly once.
  logic [4:0]  kb[5] = '{5'h01, 5'h02, 5'h04, 5'h05, 5'h06};
  logic [7:0]  kv[5] = '{8'h1f, 8'h00, 8'h70, 8'h08, 8'h08};
  int          lat[2] = '{100 * DIV, 400 * DIV};
  int          n_fail = 0, checks_done = 0, irq_n = 0, i, t;

  // Device under test.
  dpd_records #(.US_DIV(DIV)) dut (
    .clk_sys(clk_sys), .rst(rst), .input_channel(input_channel),
    .wire_break_in(wire_break_in), .aux_supply_missing(faults[2]),
    .int_comm_error(faults[1]), .diag_buf_overflow(faults[0]), .rec_rd(rec_rd),
    .rec_wr(rec_wr), .use_index(use_index), .record_number(record_number),
    .object_index(object_index), .rec_byte(rec_byte), .rec_wdata(rec_wdata),
    .rec_rdata(rec_rdata), .rec_ack(rec_ack), .rec_err(rec_err),
    .input_filtered(input_filtered), .diag_irq(diag_irq));

  // Host on the far side of the record port.
  dpd_host host (
    .clk_sys(clk_sys), .rec_rd(rec_rd), .rec_wr(rec_wr), .use_index(use_index),
    .record_number(record_number), .object_index(object_index), .rec_byte(rec_byte),
    .rec_wdata(rec_wdata));

  // Free-running clock of 10 ns.
  always #5 clk_sys = ~clk_sys;

  // Answers are checked mid-cycle, where the one-cycle pulse is settled.
  always @(negedge clk_sys) begin
    if (rec_ack === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("BAD %0t answer without request", $time);
      end else begin
        exp_v = exp_q.pop_front();
        `CHK({rec_err, rec_rdata}, exp_v)
      end
    end
    if (diag_irq === 1'b1) begin
      irq_n++;
    end
  end

  // Note the expected answer, then let the host issue the request.
  task automatic acc(input logic w, input logic ix, input logic [7:0] rn,
                     input logic [15:0] oi, input logic [4:0] b, input logic [7:0] d,
                     input logic [8:0] e);
    exp_q.push_back(e);
    host.req(w, ix, rn, oi, b, d);
  endtask

  // Bounded wait until every request has been answered.
  task automatic drain();
    for (t = 0; t < 20 && exp_q.size() != 0; t++) @(posedge clk_sys);
    if (exp_q.size() != 0) begin
      n_fail++;
      $display("BAD %0t answers missing", $time);
      print_verdict();
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // A hang anywhere counts as a mismatch.
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    $display("BAD %0t timeout", $time);
    print_verdict();
  end

  // Main sequence.
  initial begin
    void'($urandom(32'hf05ec593));
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    // Parameter reset values, read through the index path.
    for (i = 0; i < 6; i++) begin
      acc(1'b0, 1'b1, '0, 16'h3100 + 16'(i), '0, '0, (i < 2) ? 9'h000 : 9'h011);
    end
    // Fixed identification bytes on both full-record paths.
    for (i = 0; i < 5; i++) begin
      acc(1'b0, 1'b0, 8'h01, '0, kb[i], '0, {1'b0, kv[i]});
      acc(1'b0, 1'b1, '0, 16'h2f01, kb[i], '0, {1'b0, kv[i]});
    end
    // Short reads stop after four bytes; unmapped and read-only places are refused.
    acc(1'b0, 1'b0, 8'h00, '0, 5'h03, '0, 9'h000);
    acc(1'b0, 1'b0, 8'h00, '0, 5'h04, '0, 9'h100);
    acc(1'b0, 1'b1, '0, 16'h2f00, 5'h04, '0, 9'h100);
    acc(1'b0, 1'b0, 8'h05, '0, '0, '0, 9'h100);
    acc(1'b1, 1'b0, 8'h01, '0, '0, 8'h00, 9'h100);
    // An interrupt enable value other than off or on is refused and not stored.
    acc(1'b1, 1'b0, 8'h00, '0, '0, 8'h55, 9'h100);
    acc(1'b0, 1'b1, '0, 16'h3100, '0, '0, 9'h000);
    drain();
    // Module-level faults with the interrupt still off.
    faults <= 3'b111;
    repeat (3) @(posedge clk_sys);
    acc(1'b0, 1'b0, 8'h01, '0, 5'h00, '0, 9'h017);
    acc(1'b0, 1'b0, 8'h01, '0, 5'h03, '0, 9'h018);
    drain();
    `CHK(irq_n, 0)
    faults <= 3'b000;
    // Enable the interrupt and a random set of wire-break channels, then break all wires.
    wbe = 8'($urandom) | 8'h01;
    acc(1'b1, 1'b1, '0, 16'h3100, '0, 8'h40, 9'h000);
    acc(1'b1, 1'b0, 8'h00, '0, 5'h01, wbe, 9'h000);
    drain();
    wire_break_in <= 8'hff;
    repeat (3) @(posedge clk_sys);
    acc(1'b0, 1'b0, 8'h01, '0, 5'h07, '0, {1'b0, wbe});
    for (i = 0; i < 8; i++) begin
      acc(1'b0, 1'b0, 8'h01, '0, 5'h08 + 5'(i), '0, {4'h0, wbe[i], 4'h0});
    end
    acc(1'b0, 1'b0, 8'h01, '0, 5'h00, '0, 9'h00d);
    drain();
    `CHK(irq_n > 0, 1'b1)
    wire_break_in <= 8'h00;
    // Filter bytes: pair 0 fixed to codes 1 and 2, the rest random legal codes.
    for (i = 0; i < 4; i++) begin
      f = (i == 0) ? 8'h21 : {4'(1 + $urandom % 7), 4'(1 + $urandom % 7)};
      acc(1'b1, 1'b0, 8'h80 + 8'(i), '0, '0, f, 9'h000);
      acc(1'b0, 1'b1, '0, 16'h3102 + 16'(i), '0, '0, {1'b0, f});
    end
    drain();
    // Even channel follows after code-1 time, odd channel after code-2 time.
    for (i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      input_channel <= 8'h01 << i;
      for (t = 0; t < 1000 && input_filtered[i] !== 1'b1; t++) @(negedge clk_sys);
      `CHK(t >= lat[i] && t <= lat[i] + DIV + 4, 1'b1)
    end
    drain();
    print_verdict();
  end
endmodule
